// ### design/dpvi_pkg.sv
// Constants for the DSCP priority map and PVID insertion register bank.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package dpvi_pkg;

	// ---------------------------------------------------------------
	// Bus geometry
	// ---------------------------------------------------------------
	localparam int unsigned APB_DW = 32;
	localparam int unsigned APB_AW = 12;
	localparam int unsigned REG_W = 8;
	localparam int unsigned IDX_W = 8;

	// ---------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ---------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_GLOBAL_CTRL = 8'h87;
	localparam logic [IDX_W-1:0] IDX_DSCP_MAP_13 = 8'h9D;
	localparam logic [IDX_W-1:0] IDX_DSCP_MAP_14 = 8'h9E;
	localparam logic [IDX_W-1:0] IDX_DSCP_MAP_15 = 8'h9F;
	localparam logic [IDX_W-1:0] IDX_PORT1_INS = 8'hB0;
	localparam logic [IDX_W-1:0] IDX_PORT2_INS = 8'hC0;
	localparam logic [IDX_W-1:0] IDX_PORT3_INS = 8'hD0;
	localparam logic [IDX_W-1:0] IDX_PORT4_INS = 8'hE0;
	localparam logic [IDX_W-1:0] IDX_PORT5_INS = 8'hF0;
	localparam logic [1:0] IDX_SHIFT = 2'h2;

	// ---------------------------------------------------------------
	// Field layout and reset values
	// ---------------------------------------------------------------
	localparam int unsigned GLOBAL_INS_EN_BIT = 2;
	localparam int unsigned PORT_INS_HI_BIT = 3;
	localparam logic [REG_W-1:0] GLOBAL_CTRL_MASK = 8'h04;
	localparam logic [REG_W-1:0] PORT_INS_MASK = 8'h08;
	localparam logic [REG_W-1:0] DSCP_MAP_MASK = 8'hFF;
	localparam logic [REG_W-1:0] REG_RESET = 8'h00;
	localparam int unsigned PRIO_W = 2;
	localparam int unsigned FIELDS_PER_REG = 4;

	// ---------------------------------------------------------------
	// DSCP range held here
	// ---------------------------------------------------------------
	localparam int unsigned DSCP_W = 6;
	localparam logic [DSCP_W-1:0] DSCP_FIRST = 6'h34;
	localparam logic [DSCP_W-1:0] DSCP_LAST = 6'h3F;
	localparam int unsigned MAP_REGS = 3;

	// ---------------------------------------------------------------
	// Port numbering
	// ---------------------------------------------------------------
	localparam int unsigned NUM_PORTS = 5;
	localparam int unsigned PORT_W = 3;
	localparam logic [PORT_W-1:0] PORT_FIRST = 3'h1;
	localparam logic [PORT_W-1:0] PORT_LAST = 3'h5;
	localparam logic [PORT_W-1:0] HI_EGRESS_LOW_SRC = 3'h5;
	localparam logic [PORT_W-1:0] HI_EGRESS_PORT5_SRC = 3'h4;

endpackage

// ### design/dpvi_reg.sv
// One 8-bit software register with a mask of implemented bits.
// Assumes a synchronous active-low reset and a shared clock enable.
`timescale 1ns/1ps
module dpvi_reg #(
	parameter int unsigned WIDTH = 8,
	parameter logic [WIDTH-1:0] MASK = '1,
	parameter logic [WIDTH-1:0] RESET = '0
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic i_we,
	input wire logic [WIDTH-1:0] i_wdata,
	output logic [WIDTH-1:0] o_q
);

	logic [WIDTH-1:0] val_q;

	// Unimplemented bits are never stored, so they read as zero
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			val_q <= RESET & MASK;
		end else if (i_clk_en && i_we) begin
			val_q <= i_wdata & MASK;
		end
	end

	assign o_q = val_q;

endmodule

// ### design/dpvi_top.sv
// DSCP priority map (code points 0x34..0x3F) and highest-egress PVID
// insertion control, reached over an APB slave port.
// Assumes the forwarding path runs on the same clock as the bus.
//
// Operation
// - Register 0x9D holds four read/write 2-bit priorities for DSCP 0x34 to 0x37, lowest code in bits 1-0, reset 00.
// - Register 0x9E holds four read/write 2-bit priorities for DSCP 0x38 to 0x3B, lowest code in bits 1-0, reset 00.
// - Register 0x9F holds four read/write 2-bit priorities for DSCP 0x3C to 0x3F, lowest code in bits 1-0, reset 00.
// - IPv4 and IPv6 packets take their priority from the very same field.
// - Each port has a read/write bit 3, reset 0, asking for its PVID on untagged frames sent to its highest egress port.
// - For source ports 1 to 4 the highest egress port is port 5.
// - For source port 5 the highest egress port is port 4.
// - Insertion happens only while bit 2 of register 135 is set.
`timescale 1ns/1ps
module dpvi_top #(
	parameter int unsigned ADDR_W = dpvi_pkg::APB_AW
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [dpvi_pkg::APB_DW-1:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic o_pready,
	output logic [dpvi_pkg::APB_DW-1:0] o_prdata,
	output logic o_pslverr,
	// DSCP classification request
	input wire logic i_cls_valid,
	input wire logic [dpvi_pkg::DSCP_W-1:0] i_cls_dscp,
	input wire logic i_cls_ipv6,
	output logic o_cls_valid,
	output logic o_cls_hit,
	output logic [dpvi_pkg::PRIO_W-1:0] o_cls_prio,
	// Egress tagging request
	input wire logic i_egr_valid,
	input wire logic [dpvi_pkg::PORT_W-1:0] i_egr_src_port,
	input wire logic [dpvi_pkg::PORT_W-1:0] i_egr_dst_port,
	input wire logic i_egr_untagged,
	output logic o_egr_valid,
	output logic o_egr_insert_pvid,
	output logic [dpvi_pkg::PORT_W-1:0] o_egr_src_port
);

	// ---------------------------------------------------------------
	// Types and storage
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		SEL_NONE,
		SEL_GLOBAL,
		SEL_MAP13,
		SEL_MAP14,
		SEL_MAP15,
		SEL_PORT1,
		SEL_PORT2,
		SEL_PORT3,
		SEL_PORT4,
		SEL_PORT5
	} dpvi_sel_t;

	localparam int unsigned RW = dpvi_pkg::REG_W;
	localparam int unsigned NP = dpvi_pkg::NUM_PORTS;
	localparam int unsigned NM = dpvi_pkg::MAP_REGS;
	localparam int unsigned TBL_W = NM * RW;

	logic [RW-1:0] map_q [NM];
	logic [RW-1:0] port_q [NP];
	logic [RW-1:0] global_q;
	logic [TBL_W-1:0] table_flat;

	dpvi_sel_t sel;
	logic addr_aligned;
	logic [dpvi_pkg::IDX_W-1:0] reg_idx;
	logic wr_fire;
	logic wr_lane0;
	logic [RW-1:0] rd_val;

	logic [NM-1:0] map_we;
	logic [NP-1:0] port_we;
	logic global_we;

	logic [dpvi_pkg::APB_DW-1:0] prdata_q;
	logic pslverr_q;

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	// Printed offsets are word indices, so the byte address is
	// the index shifted up by two; anything unaligned is unmapped.
	assign addr_aligned = (i_paddr[1:0] == 2'h0);
	assign reg_idx = i_paddr[dpvi_pkg::IDX_W+1:2];

	// Only the low 256 words exist; anything above is unmapped
	always_comb begin
		sel = SEL_NONE;
		if (addr_aligned && i_paddr[ADDR_W-1:dpvi_pkg::IDX_W+2] == '0)
		begin
			unique case (reg_idx)
				dpvi_pkg::IDX_GLOBAL_CTRL: sel = SEL_GLOBAL;
				dpvi_pkg::IDX_DSCP_MAP_13: sel = SEL_MAP13;
				dpvi_pkg::IDX_DSCP_MAP_14: sel = SEL_MAP14;
				dpvi_pkg::IDX_DSCP_MAP_15: sel = SEL_MAP15;
				dpvi_pkg::IDX_PORT1_INS: sel = SEL_PORT1;
				dpvi_pkg::IDX_PORT2_INS: sel = SEL_PORT2;
				dpvi_pkg::IDX_PORT3_INS: sel = SEL_PORT3;
				dpvi_pkg::IDX_PORT4_INS: sel = SEL_PORT4;
				dpvi_pkg::IDX_PORT5_INS: sel = SEL_PORT5;
				default: sel = SEL_NONE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Write strobes
	// ---------------------------------------------------------------
	// Writes land at the access edge; the data sits in byte lane 0,
	// so a write without that strobe leaves the register alone.
	assign wr_fire = i_psel && i_penable && i_pwrite && o_pready;
	assign wr_lane0 = wr_fire && i_pstrb[0];

	always_comb begin
		map_we = '0;
		port_we = '0;
		global_we = 1'b0;
		unique case (sel)
			SEL_GLOBAL: global_we = wr_lane0;
			SEL_MAP13: map_we[0] = wr_lane0;
			SEL_MAP14: map_we[1] = wr_lane0;
			SEL_MAP15: map_we[2] = wr_lane0;
			SEL_PORT1: port_we[0] = wr_lane0;
			SEL_PORT2: port_we[1] = wr_lane0;
			SEL_PORT3: port_we[2] = wr_lane0;
			SEL_PORT4: port_we[3] = wr_lane0;
			SEL_PORT5: port_we[4] = wr_lane0;
			SEL_NONE: begin
			end
		endcase
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	// One register per map word, lowest code points first
	genvar gi;
	generate
		for (gi = 0; gi < NM; gi++) begin : g_map
			dpvi_reg #(
				.WIDTH(RW),
				.MASK(dpvi_pkg::DSCP_MAP_MASK),
				.RESET(dpvi_pkg::REG_RESET)
			) u_map (
				.i_sys_clk(i_sys_clk),
				.i_rst_n(i_rst_n),
				.i_clk_en(i_clk_en),
				.i_we(map_we[gi]),
				.i_wdata(i_pwdata[RW-1:0]),
				.o_q(map_q[gi])
			);
		end
		// Only bit 3 is kept; upper and lower bits read zero
		for (gi = 0; gi < NP; gi++) begin : g_port
			dpvi_reg #(
				.WIDTH(RW),
				.MASK(dpvi_pkg::PORT_INS_MASK),
				.RESET(dpvi_pkg::REG_RESET)
			) u_port (
				.i_sys_clk(i_sys_clk),
				.i_rst_n(i_rst_n),
				.i_clk_en(i_clk_en),
				.i_we(port_we[gi]),
				.i_wdata(i_pwdata[RW-1:0]),
				.o_q(port_q[gi])
			);
		end
	endgenerate

	// Only the insertion enable of the global register lives here
	dpvi_reg #(
		.WIDTH(RW),
		.MASK(dpvi_pkg::GLOBAL_CTRL_MASK),
		.RESET(dpvi_pkg::REG_RESET)
	) u_global (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_we(global_we),
		.i_wdata(i_pwdata[RW-1:0]),
		.o_q(global_q)
	);

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	always_comb begin
		rd_val = '0;
		unique case (sel)
			SEL_GLOBAL: rd_val = global_q;
			SEL_MAP13: rd_val = map_q[0];
			SEL_MAP14: rd_val = map_q[1];
			SEL_MAP15: rd_val = map_q[2];
			SEL_PORT1: rd_val = port_q[0];
			SEL_PORT2: rd_val = port_q[1];
			SEL_PORT3: rd_val = port_q[2];
			SEL_PORT4: rd_val = port_q[3];
			SEL_PORT5: rd_val = port_q[4];
			SEL_NONE: rd_val = '0;
		endcase
	end

	// Read data and error are captured in the setup cycle, so the
	// access phase always completes with no wait state.
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			prdata_q <= '0;
			pslverr_q <= 1'b0;
		end else if (i_clk_en) begin
			if (i_psel && !i_penable) begin
				prdata_q <= {{(dpvi_pkg::APB_DW-RW){1'b0}}, rd_val};
				pslverr_q <= (sel == SEL_NONE);
			end
		end
	end

	assign o_pready = i_psel && i_penable;
	assign o_prdata = prdata_q;
	assign o_pslverr = pslverr_q && o_pready;

	// ---------------------------------------------------------------
	// DSCP classification
	// ---------------------------------------------------------------
	logic cls_in_range;
	logic [dpvi_pkg::DSCP_W-1:0] cls_off;
	logic [dpvi_pkg::PRIO_W-1:0] cls_prio_d;
	logic cls_valid_q;
	logic cls_hit_q;
	logic [dpvi_pkg::PRIO_W-1:0] cls_prio_q;

	assign table_flat = {map_q[2], map_q[1], map_q[0]};
	assign cls_in_range = (i_cls_dscp >= dpvi_pkg::DSCP_FIRST) &&
		(i_cls_dscp <= dpvi_pkg::DSCP_LAST);
	assign cls_off = i_cls_dscp - dpvi_pkg::DSCP_FIRST;

	// Code point order runs upward through the three map registers
	always_comb begin
		cls_prio_d = '0;
		if (cls_in_range) begin
			cls_prio_d = table_flat[{cls_off[3:0], 1'b0} +:
				dpvi_pkg::PRIO_W];
		end
	end

	// The IP version flag is deliberately unused for selection,
	// so an IPv6 packet can never read a different field
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			cls_valid_q <= 1'b0;
			cls_hit_q <= 1'b0;
			cls_prio_q <= '0;
		end else if (i_clk_en) begin
			cls_valid_q <= i_cls_valid;
			if (i_cls_valid) begin
				cls_hit_q <= cls_in_range;
				cls_prio_q <= cls_prio_d;
			end
		end
	end

	assign o_cls_valid = cls_valid_q;
	assign o_cls_hit = cls_hit_q;
	assign o_cls_prio = cls_prio_q;

	// ---------------------------------------------------------------
	// Egress PVID insertion
	// ---------------------------------------------------------------
	logic src_ok;
	logic [dpvi_pkg::PORT_W-1:0] src_idx;
	logic [dpvi_pkg::PORT_W-1:0] hi_egress;
	logic src_ins_bit;
	logic [NP-1:0] port_ins_en;
	logic global_en;
	logic ins_d;
	logic egr_valid_q;
	logic ins_q;
	logic [dpvi_pkg::PORT_W-1:0] egr_src_q;

	assign src_ok = (i_egr_src_port >= dpvi_pkg::PORT_FIRST) &&
		(i_egr_src_port <= dpvi_pkg::PORT_LAST);
	assign src_idx = i_egr_src_port - dpvi_pkg::PORT_FIRST;
	assign global_en = global_q[dpvi_pkg::GLOBAL_INS_EN_BIT];

	// Port 5 cannot send to itself, so its top egress is port 4
	always_comb begin
		if (i_egr_src_port == dpvi_pkg::PORT_LAST) begin
			hi_egress = dpvi_pkg::HI_EGRESS_PORT5_SRC;
		end else begin
			hi_egress = dpvi_pkg::HI_EGRESS_LOW_SRC;
		end
	end

	// Gathered once so the source lookup indexes a plain vector
	always_comb begin
		for (int p = 0; p < NP; p++) begin
			port_ins_en[p] = port_q[p][dpvi_pkg::PORT_INS_HI_BIT];
		end
	end

	// A source number outside 1..5 would index past the vector
	always_comb begin
		src_ins_bit = 1'b0;
		if (src_ok) begin
			src_ins_bit = port_ins_en[src_idx];
		end
	end

	// Tagged frames keep their own tag; only untagged ones gain PVID
	assign ins_d = global_en && src_ok && src_ins_bit &&
		i_egr_untagged && (i_egr_dst_port == hi_egress);

	// Source echo lets the tagger fetch that port's PVID
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			egr_valid_q <= 1'b0;
			ins_q <= 1'b0;
			egr_src_q <= '0;
		end else if (i_clk_en) begin
			egr_valid_q <= i_egr_valid;
			if (i_egr_valid) begin
				ins_q <= ins_d;
				egr_src_q <= i_egr_src_port;
			end
		end
	end

	assign o_egr_valid = egr_valid_q;
	assign o_egr_insert_pvid = ins_q;
	assign o_egr_src_port = egr_src_q;

endmodule

// ### sim/dpvi_chk.sv
// Port assertions for the DSCP map and PVID insertion bank.
// Assumes it is bound onto dpvi_top and requests come with clock enable high.
`timescale 1ns/1ps
module dpvi_chk #(
	parameter int unsigned ADDR_W = 12
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic i_cls_valid,
	input wire logic [5:0] i_cls_dscp,
	input wire logic o_cls_valid,
	input wire logic o_cls_hit,
	input wire logic [1:0] o_cls_prio,
	input wire logic i_egr_valid,
	input wire logic [2:0] i_egr_src_port,
	input wire logic [2:0] i_egr_dst_port,
	input wire logic i_egr_untagged,
	input wire logic o_egr_valid,
	input wire logic o_egr_insert_pvid,
	input wire logic [2:0] o_egr_src_port
);
	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	AST_CLS_LAT: assert property (i_cls_valid |=> o_cls_valid)
		else $error("classify answer late");
	AST_CLS_MISS: assert property (i_cls_valid && i_cls_dscp < 6'h34
		|=> !o_cls_hit && o_cls_prio == 2'h0) else $error("hit below range");
	AST_CLS_HIT: assert property (i_cls_valid && i_cls_dscp >= 6'h34
		|-> ##1 o_cls_hit) else $error("miss inside range");
	AST_CLS_HOLD: assert property (!i_cls_valid |=> $stable(o_cls_prio))
		else $error("priority moved without request");
	AST_EGR_LAT: assert property (i_egr_valid |=> o_egr_valid
		&& o_egr_src_port == $past(i_egr_src_port)) else $error("egress echo");
	AST_EGR_TAGGED: assert property (i_egr_valid && !i_egr_untagged
		|=> !o_egr_insert_pvid) else $error("insert on tagged frame");
	AST_EGR_LOW: assert property (i_egr_valid && i_egr_src_port < 3'h5
		&& i_egr_dst_port != 3'h5 |=> !o_egr_insert_pvid)
		else $error("insert off highest egress");
	AST_EGR_P5: assert property (i_egr_valid && i_egr_src_port == 3'h5
		&& i_egr_dst_port != 3'h4 |=> !o_egr_insert_pvid)
		else $error("port 5 insert off port 4");
	AST_PORT_RSVD: assert property (i_psel && i_penable && !i_pwrite
		&& i_paddr[5:0] == 6'h00 && i_paddr[11:6] inside {[6'h0B:6'h0F]}
		|-> o_prdata[7:4] == 4'h0) else $error("reserved bits set");
endmodule
bind dpvi_top dpvi_chk #(.ADDR_W(ADDR_W)) i_dpvi_chk (.i_sys_clk(i_sys_clk),
	.i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata),
	.i_cls_valid(i_cls_valid), .i_cls_dscp(i_cls_dscp),
	.o_cls_valid(o_cls_valid), .o_cls_hit(o_cls_hit), .o_cls_prio(o_cls_prio),
	.i_egr_valid(i_egr_valid), .i_egr_src_port(i_egr_src_port),
	.i_egr_dst_port(i_egr_dst_port), .i_egr_untagged(i_egr_untagged),
	.o_egr_valid(o_egr_valid), .o_egr_insert_pvid(o_egr_insert_pvid),
	.o_egr_src_port(o_egr_src_port));

// ### sim/tb.sv
// Self-checking bench for the DSCP map and PVID insertion bank.
// Assumes the checker file is compiled with it; clock enable drops only
// in the freeze test.
`timescale 1ns/1ps
module tb;
	logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, ce = 1;
	logic [11:0] padr = 12'h000;
	logic [31:0] pwd = 32'h0, prd, rdat;
	logic rdy, err, rerr, cv = 0, v6 = 0, ocv, hit, ev = 0, unt = 0, oev, ins;
	logic [5:0] dscp = 6'h00;
	logic [1:0] prio;
	logic [2:0] src = 3'h0, dst = 3'h0, osrc;
	logic [7:0] mapv [3] = '{8'hE4, 8'h1B, 8'h9C};
	logic [11:0] regs [9] = '{12'h274, 12'h278, 12'h27C, 12'h21C, 12'h2C0,
		12'h300, 12'h340, 12'h380, 12'h3C0};
	int fail_count = 0, total_checks = 0, cyc = 0, wst = 0;
	dpvi_top i_dpvi_top (.i_sys_clk(clk), .i_rst_n(rst_n), .i_clk_en(ce),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr),
		.i_pwdata(pwd), .i_pstrb(4'hF), .o_pready(rdy), .o_prdata(prd),
		.o_pslverr(err), .i_cls_valid(cv), .i_cls_dscp(dscp),
		.i_cls_ipv6(v6), .o_cls_valid(ocv), .o_cls_hit(hit),
		.o_cls_prio(prio), .i_egr_valid(ev), .i_egr_src_port(src),
		.i_egr_dst_port(dst), .i_egr_untagged(unt), .o_egr_valid(oev),
		.o_egr_insert_pvid(ins), .o_egr_src_port(osrc));
	initial forever #12.5 clk = ~clk;
	// Whole run needs well under 1000 cycles; ceiling leaves margin
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			fail_count++;
			wrap_up();
		end
	end
	// ---------------------------------------------------------------
	// Bus and request tasks
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Ready, read data and error are all taken at one rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pen <= 0;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1;
		wst = -1;
		do begin
			@(posedge clk);
			wst++;
		end while (rdy !== 1'b1);
		rdat = prd;
		rerr = err;
		psel <= 0;
		pen <= 0;
	endtask
	task automatic cls(input logic [5:0] d, input logic six);
		@(posedge clk);
		cv <= 1;
		dscp <= d;
		v6 <= six;
		@(posedge clk);
		cv <= 0;
		@(negedge clk);
	endtask
	task automatic egr(input logic [2:0] s, d, input logic u, e);
		@(posedge clk);
		ev <= 1;
		src <= s;
		dst <= d;
		unt <= u;
		@(posedge clk);
		ev <= 0;
		@(negedge clk);
		chk("egr_valid", oev, 1);
		chk("egr_src", osrc, s);
		chk("insert", ins, e);
	endtask
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		foreach (regs[i]) begin
			apb(0, regs[i], 0);
			chk("reset value", rdat, 0);
		end
		$display("reset values done");
	endtask
	task automatic t_map();
		int k;
		logic [1:0] ep;
		for (int i = 0; i < 3; i++) apb(1, regs[i], {24'h0, mapv[i]});
		for (int i = 0; i < 3; i++) begin
			apb(0, regs[i], 0);
			chk("map readback", rdat, {24'h0, mapv[i]});
		end
		for (int d = 'h33; d <= 'h3F; d++) begin
			k = d - 'h34;
			ep = (d < 'h34) ? 2'h0 : 2'(mapv[k / 4] >> (2 * (k % 4)));
			for (int s = 0; s < 2; s++) begin
				cls(6'(d), 1'(s));
				chk("cls_valid", ocv, 1);
				chk("cls_hit", hit, d >= 'h34);
				chk("cls_prio", prio, ep);
			end
		end
		$display("dscp map done");
	endtask
	// A write while clock enable is low must not land
	task automatic t_freeze();
		@(posedge clk);
		ce <= 0;
		apb(1, 12'h274, 32'h0);
		ce <= 1;
		apb(0, 12'h274, 0);
		chk("frozen map", rdat, {24'h0, mapv[0]});
		$display("clock enable freeze done");
	endtask
	task automatic t_port();
		for (int i = 4; i < 9; i++) begin
			apb(1, regs[i], 32'hFFFFFFFF);
			apb(0, regs[i], 0);
			chk("port ctrl", rdat, 32'h08);
			chk("port err", rerr, 0);
			chk("pready waits", wst, 0);
		end
		apb(0, 12'h2C4, 0);
		chk("unmapped err", rerr, 1);
		chk("unmapped data", rdat, 0);
		$display("port control done");
	endtask
	task automatic t_egr();
		for (int s = 1; s < 6; s++) egr(3'(s), s == 5 ? 3'h4 : 3'h5, 1, 0);
		apb(1, 12'h21C, 32'hFF);
		apb(0, 12'h21C, 0);
		chk("global ctrl", rdat, 32'h04);
		for (int s = 1; s < 6; s++) begin
			egr(3'(s), s == 5 ? 3'h4 : 3'h5, 1, 1);
			egr(3'(s), s == 5 ? 3'h4 : 3'h5, 0, 0);
			egr(3'(s), s == 5 ? 3'h5 : 3'h4, 1, 0);
		end
		apb(1, 12'h340, 0);
		egr(3'h3, 3'h5, 1, 0);
		egr(3'h2, 3'h5, 1, 1);
		$display("egress insertion done");
	endtask
	// ---------------------------------------------------------------
	// Main sequence and verdict
	// ---------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1;
		t_reset();
		t_map();
		t_freeze();
		t_port();
		t_egr();
		wrap_up();
	end
endmodule
